// [rtl/sslr_pkg.sv]
// Purpose: Constants for the secondary serial rate configuration block
// Assumes: Rates are expressed in Hz, 20-bit unsigned
// Notes: Rate table index 0 stands for automatic detection
package sslr_pkg;
   localparam logic [7:0] SSLR_REG_OFFSET = 8'h33;
   localparam logic [7:0] SSLR_REG_RESET = 8'h00;
   localparam int SSLR_SEL_MSB = 7;
   localparam int SSLR_SEL_LSB = 2;
   localparam int SSLR_TOL_BIT = 1;
   localparam logic [5:0] SSLR_CODE_AUTO = 6'h00;
   localparam logic [5:0] SSLR_CODE_FIRST = 6'h01;
   localparam logic [5:0] SSLR_CODE_LAST = 6'h28;
   localparam logic [2:0] SSLR_TOL_TIGHT_PCT = 3'h1;
   localparam logic [2:0] SSLR_TOL_LOOSE_PCT = 3'h5;
   localparam logic [6:0] SSLR_PCT_SCALE = 7'h64;
   localparam int SSLR_RATE_W = 20;

   typedef logic [SSLR_RATE_W-1:0] sslr_rate_t;

   localparam sslr_rate_t SSLR_NOM [0:40] = '{0,
      768000, 614400, 512000, 438857, 384000, 341333, 307200, 256000,
      219429, 192000, 170667, 153600, 128000, 109714, 96000, 85333,
      76800, 64000, 54857, 48000, 42667, 38400, 32000, 27429,
      24000, 21333, 19200, 16000, 13714, 12000, 10667, 9600,
      8000, 6857, 6000, 5333, 4800, 4000, 3429, 3000};
   localparam sslr_rate_t SSLR_LO [0:40] = '{0,
      670320, 536256, 446880, 383040, 335160, 297920, 268128, 223440,
      191520, 167580, 148960, 134064, 111720, 95760, 83790, 74480,
      67032, 55860, 47880, 41895, 37240, 33516, 27930, 23940,
      20947, 18620, 16758, 13965, 11970, 10473, 9310, 8379,
      6982, 5985, 5236, 4655, 4189, 3491, 2992, 2618};
   localparam sslr_rate_t SSLR_HI [0:40] = '{0,
      791040, 632832, 527360, 452022, 395520, 351573, 316416, 263680,
      226011, 197760, 175786, 158208, 131840, 113005, 98880, 87893,
      79104, 65920, 56502, 49440, 43946, 39552, 32960, 28251,
      24720, 21973, 19776, 16480, 14125, 12360, 10986, 9888,
      8240, 7062, 6180, 5493, 4944, 4120, 3531, 3090};

   typedef enum logic [1:0] {
      SSLR_IDLE = 2'b00,
      SSLR_SCAN = 2'b01
   } sslr_state_t;
endpackage : sslr_pkg

// [rtl/sslr_rate_table.sv]
// Purpose: Maps a rate selection code to nominal rate and allowed range
// Assumes: Codes above the last defined one are reserved
// Notes: Purely combinational lookup
`timescale 1ns/100ps
`default_nettype none
module sslr_rate_table
   import sslr_pkg::*;
(
   input wire logic [5:0] code_i,
   output logic [SSLR_RATE_W-1:0] nom_o,
   output logic [SSLR_RATE_W-1:0] lo_o,
   output logic [SSLR_RATE_W-1:0] hi_o,
   output logic defined_o
);
   wire logic in_table;
   assign in_table = (code_i >= SSLR_CODE_FIRST) && (code_i <= SSLR_CODE_LAST);
   assign defined_o = in_table;
   assign nom_o = in_table ? SSLR_NOM[code_i] : '0;
   assign lo_o = in_table ? SSLR_LO[code_i] : '0;
   assign hi_o = in_table ? SSLR_HI[code_i] : '0;
endmodule : sslr_rate_table
`default_nettype wire

// [rtl/sslr_core.sv]
// Purpose: Secondary serial link rate configuration register and rate check
// Assumes: Register port and measured rate are synchronous to clk_i
// Notes: Auto mode scans the rate table one code per cycle
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// RL1: Six-bit rate select in bits 7..2, reset zero; zero means automatic detection.
// RL2: Code 1 selects 768000 Hz nominal, allowed 670320 to 791040 Hz.
// RL3: Code 20 selects 48000 Hz, allowed 41895 to 49440; others follow table.
// RL4: Code 40 selects 3000 Hz, allowed 2618 to 3090 Hz.
// RL5: Host must not write reserved codes 41 to 63.
// RL6: Tolerance bit clear: auto detection accepts standard rates within 1 percent.
// RL7: Tolerance bit set: auto detection accepts standard rates within 5 percent.
// RL8: Bit 0 reserved, reads zero, host writes zero.
module sslr_core
   import sslr_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic meas_valid_i,
   input wire logic [SSLR_RATE_W-1:0] meas_rate_i,
   output logic busy_o,
   output logic done_o,
   output logic rate_ok_o,
   output logic [5:0] rate_code_o,
   output logic [5:0] secondary_rate_select_o,
   output logic secondary_rate_tolerance_o,
   output logic reserved_sel_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Register
   logic [5:0] rate_select;
   logic tolerance;
   logic [7:0] rdata;
   wire logic hit_addr;
   wire logic [7:0] reg_value;

   assign hit_addr = (reg_addr_i == SSLR_REG_OFFSET);
   assign reg_value = {rate_select, tolerance, 1'b0};

   // RL1: select field storage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rate_select <= SSLR_REG_RESET[SSLR_SEL_MSB:SSLR_SEL_LSB];
         tolerance <= SSLR_REG_RESET[SSLR_TOL_BIT];
      end else if (ce_i && reg_wr_i && hit_addr) begin
         rate_select <= reg_wdata_i[SSLR_SEL_MSB:SSLR_SEL_LSB];
         tolerance <= reg_wdata_i[SSLR_TOL_BIT];
      end
   end

   // RL8: reserved bit reads zero
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         rdata <= hit_addr ? reg_value : 8'h00;
      end
   end

   assign reg_rdata_o = rdata;
   assign secondary_rate_select_o = rate_select;
   assign secondary_rate_tolerance_o = tolerance;
   assign reserved_sel_o = (rate_select > SSLR_CODE_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Rate check
   sslr_state_t state;
   logic [5:0] idx;
   logic [SSLR_RATE_W-1:0] meas;
   logic scan_auto;
   logic scan_tol;
   logic done;
   logic ok;
   logic [5:0] code_out;
   wire logic [SSLR_RATE_W-1:0] t_nom;
   wire logic [SSLR_RATE_W-1:0] t_lo;
   wire logic [SSLR_RATE_W-1:0] t_hi;
   wire logic t_def;
   wire logic range_hit;
   wire logic tol_hit;
   wire logic hit;
   wire logic last;

   // RL3 RL4: rate table lookup
   sslr_rate_table u_table (
      .code_i(idx),
      .nom_o(t_nom),
      .lo_o(t_lo),
      .hi_o(t_hi),
      .defined_o(t_def)
   );

   function automatic logic within_pct(input logic [SSLR_RATE_W-1:0] m,
                                       input logic [SSLR_RATE_W-1:0] n,
                                       input logic [2:0] pct);
      logic [SSLR_RATE_W-1:0] diff;
      logic [27:0] lhs;
      logic [27:0] rhs;
      diff = (m > n) ? (m - n) : (n - m);
      lhs = 28'(diff) * 28'(SSLR_PCT_SCALE);
      rhs = 28'(n) * 28'(pct);
      return lhs <= rhs;
   endfunction : within_pct

   // RL2: forced code range check
   assign range_hit = t_def && (meas >= t_lo) && (meas <= t_hi);
   // RL6 RL7: tolerance select
   assign tol_hit = t_def && within_pct(meas, t_nom,
                    scan_tol ? SSLR_TOL_LOOSE_PCT : SSLR_TOL_TIGHT_PCT);
   assign hit = scan_auto ? tol_hit : range_hit;
   assign last = !scan_auto || (idx == SSLR_CODE_LAST);

   // RL1: auto scan or forced code
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= SSLR_IDLE;
         idx <= SSLR_CODE_AUTO;
         meas <= '0;
         scan_auto <= 1'b0;
         scan_tol <= 1'b0;
         done <= 1'b0;
         ok <= 1'b0;
         code_out <= SSLR_CODE_AUTO;
      end else if (ce_i) begin
         done <= 1'b0;
         unique case (state)
            SSLR_IDLE: begin
               if (meas_valid_i) begin
                  meas <= meas_rate_i;
                  scan_auto <= (rate_select == SSLR_CODE_AUTO);
                  scan_tol <= tolerance;
                  idx <= (rate_select == SSLR_CODE_AUTO) ? SSLR_CODE_FIRST : rate_select;
                  state <= SSLR_SCAN;
               end
            end
            SSLR_SCAN: begin
               if (hit || last) begin
                  ok <= hit;
                  code_out <= hit ? idx : SSLR_CODE_AUTO;
                  done <= 1'b1;
                  state <= SSLR_IDLE;
               end else begin
                  idx <= idx + 6'h01;
               end
            end
         endcase
      end
   end

   assign busy_o = (state == SSLR_SCAN);
   assign done_o = done;
   assign rate_ok_o = ok;
   assign rate_code_o = code_out;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // RL1: auto scan range
   auto_scan_a: assert property ((state == SSLR_SCAN && scan_auto) |->  // RL1
      (idx >= SSLR_CODE_FIRST && idx <= SSLR_CODE_LAST))
      else $error("auto scan index out of table");
   // RL2: top code range
   code1_range_a: assert property ((ce_i && state == SSLR_SCAN && !scan_auto && idx == 6'h01) // RL2
      |=> (ok == (meas >= 20'd670320 && meas <= 20'd791040)))
      else $error("code 1 range check wrong");
   // RL3: mid code range
   code20_range_a: assert property ((ce_i && state == SSLR_SCAN && !scan_auto && idx == 6'h14) // RL3
      |=> done && (ok == (meas >= 20'd41895 && meas <= 20'd49440)))
      else $error("code 20 range check wrong");
   // RL4: low code range
   code40_range_a: assert property ((ce_i && state == SSLR_SCAN && !scan_auto && idx == 6'h28) // RL4
      |=> done && (ok == (meas >= 20'd2618 && meas <= 20'd3090)))
      else $error("code 40 range check wrong");
   // RL6: tight tolerance
   tight_tol_a: assert property ((done && ok && scan_auto && !scan_tol) |-> // RL6
      ((((meas > t_nom) ? meas - t_nom : t_nom - meas) * 100) <= t_nom))
      else $error("auto match outside 1 percent");
   // RL7: loose tolerance
   loose_tol_a: assert property ((done && ok && scan_auto && scan_tol) |-> // RL7
      ((((meas > t_nom) ? meas - t_nom : t_nom - meas) * 100) <= t_nom * 5))
      else $error("auto match outside 5 percent");
   // RL1: scan bounded
   scan_bound_a: assert property ((ce_i && meas_valid_i && state == SSLR_IDLE) |-> // RL1
      ##[1:200] done)
      else $error("rate scan did not finish");
   // RL8: read of reserved bit
   rsv_bit_a: assert property ($rose(reg_rd_i) |=> !reg_rdata_o[0]) // RL8
      else $error("reserved bit read nonzero");

   // RL1: enable freezes state
   ce_hold_a: assert property (!ce_i |=> ($stable(rate_select) && $stable(tolerance) // RL1
      && $stable(state) && $stable(rdata)))
      else $error("state changed while clock enable low");
   // RL1: write lands
   wr_land_a: assert property ((ce_i && reg_wr_i && hit_addr) |=> // RL1
      (reg_value == ($past(reg_wdata_i) & 8'hFE)))
      else $error("register write did not land");
   // RL2: forced single step
   forced_one_a: assert property ((ce_i && state == SSLR_SCAN && !scan_auto) |=> // RL2
      (done && !busy_o))
      else $error("forced code check not finished in one step");
   // RL1: done single pulse
   done_pulse_a: assert property ((ce_i && done) |=> !done) // RL1
      else $error("done held longer than one cycle");
   // RL1: matched code defined
   code_match_a: assert property ((done && ok) |-> // RL1
      (code_out >= SSLR_CODE_FIRST && code_out <= SSLR_CODE_LAST))
      else $error("accepted rate reports undefined code");

   auto_hit_c: cover property (done && ok && scan_auto);
   forced_hit_c: cover property (done && ok && !scan_auto);
   miss_c: cover property (done && !ok);
   loose_hit_c: cover property (done && ok && scan_auto && scan_tol);
   ce_hold_c: cover property (!ce_i && reg_wr_i && hit_addr);
endmodule : sslr_core
`default_nettype wire

// [tb/sslr_host.sv]
// Purpose: Host model that programs the rate register
// Assumes: Bus signals change at the falling clock edge
// Notes: Released address and data lines show the inverse of their last value; write and read strobes return low
`timescale 1ns/100ps
`default_nettype none
module sslr_host (
   input wire logic clk_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
   end
   task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
      if (d[7:2] > 6'h28) d[7:2] = 6'h00;
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = {d[7:1], 1'b0};
      reg_wr_o = wr;
      reg_rd_o = !wr;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = ~reg_addr_o;
      reg_wdata_o = ~reg_wdata_o;
   endtask : access
endmodule : sslr_host
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the rate configuration block
// Assumes: Inputs change at the falling clock edge
// Notes: Expected results come from a table scan model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
   import sslr_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ce_i, reg_wr_i, reg_rd_i, meas_valid_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [SSLR_RATE_W-1:0] meas_rate_i;
   logic busy_o, done_o, rate_ok_o, secondary_rate_tolerance_o, reserved_sel_o;
   logic [5:0] rate_code_o, secondary_rate_select_o;
   int num_errors = 0;
   int checks_done = 0;
   int seed = 32'he546;
   int fc [3] = '{1, 20, 40};
   logic [6:0] exp_q [$];
   always #5 clk_i = ~clk_i;
   sslr_host sslr_host_i (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
   sslr_core sslr_core_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .meas_valid_i(meas_valid_i),
      .meas_rate_i(meas_rate_i), .busy_o(busy_o), .done_o(done_o), .rate_ok_o(rate_ok_o),
      .rate_code_o(rate_code_o), .secondary_rate_select_o(secondary_rate_select_o),
      .secondary_rate_tolerance_o(secondary_rate_tolerance_o), .reserved_sel_o(reserved_sel_o));
   task automatic close_out;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic prog(input int code, input logic tol);
      logic [7:0] v;
      v = {code[5:0], tol, 1'b0};
      sslr_host_i.access(SSLR_REG_OFFSET, v, 1'b1);
      sslr_host_i.access(SSLR_REG_OFFSET, 8'h00, 1'b0);
      @(negedge clk_i);
      `CHK("readback", v, reg_rdata_o)
      `CHK("select", v[7:2], secondary_rate_select_o)
      `CHK("tolerance", tol, secondary_rate_tolerance_o)
      `CHK("reserved", (code > 40), reserved_sel_o)
   endtask : prog
   task automatic meas(input int code, input logic tol, input int m);
      int ok;
      int hit;
      int lim;
      logic [6:0] exp_r;
      ok = 0;
      hit = 0;
      if (code != 0) begin
         ok = (m >= SSLR_LO[code] && m <= SSLR_HI[code]);
         hit = ok ? code : 0;
      end else begin
         for (int c = 40; c >= 1; c--) begin
            if ((m > SSLR_NOM[c] ? m - SSLR_NOM[c] : SSLR_NOM[c] - m) * 100
                <= SSLR_NOM[c] * (tol ? 5 : 1)) hit = c;
         end
         ok = (hit != 0);
      end
      exp_q.push_back({ok[0], hit[5:0]});
      @(negedge clk_i);
      meas_rate_i = m[SSLR_RATE_W-1:0];
      meas_valid_i = 1'b1;
      @(negedge clk_i);
      meas_valid_i = 1'b0;
      meas_rate_i = ~meas_rate_i;
      `CHK("busy", 1'b1, busy_o)
      lim = 0;
      while (done_o !== 1'b1 && lim < 50) begin
         @(negedge clk_i);
         lim++;
      end
      `CHK("done", 1'b1, done_o)
      exp_r = exp_q.pop_front();
      `CHK("ok", exp_r[6], rate_ok_o)
      `CHK("code", exp_r[5:0], rate_code_o)
      @(negedge clk_i);
      `CHK("done pulse", 1'b0, done_o)
   endtask : meas
   initial begin
      int c;
      int m;
      logic t;
      ce_i = 1'b1;
      meas_valid_i = 1'b0;
      meas_rate_i = '0;
      repeat (12) @(negedge clk_i);
      arst_n_i = 1'b1;
      sslr_host_i.access(SSLR_REG_OFFSET, 8'h00, 1'b0);
      @(negedge clk_i);
      `CHK("reset value", SSLR_REG_RESET, reg_rdata_o)
      sslr_host_i.access(8'h32, 8'h50, 1'b1);
      sslr_host_i.access(8'h32, 8'h00, 1'b0);
      @(negedge clk_i);
      `CHK("unmapped", 8'h00, reg_rdata_o)
      `CHK("unmapped write", 6'h00, secondary_rate_select_o)
      for (int j = 0; j < 3; j++) begin
         prog(fc[j], 1'b0);
         meas(fc[j], 1'b0, SSLR_LO[fc[j]] - 1);
         meas(fc[j], 1'b0, SSLR_LO[fc[j]]);
         meas(fc[j], 1'b0, SSLR_HI[fc[j]]);
         meas(fc[j], 1'b0, SSLR_HI[fc[j]] + 1);
      end
      for (int k = 0; k < 2; k++) begin
         prog(0, k[0]);
         meas(0, k[0], 49440);
      end
      ce_i = 1'b0;
      sslr_host_i.access(SSLR_REG_OFFSET, 8'h50, 1'b1);
      `CHK("frozen select", 6'h00, secondary_rate_select_o)
      `CHK("frozen tolerance", 1'b1, secondary_rate_tolerance_o)
      ce_i = 1'b1;
      repeat (40) begin
         c = $unsigned($random(seed)) % 41;
         t = $random(seed) & 1;
         prog(c, t);
         m = SSLR_NOM[(c == 0) ? 1 + $unsigned($random(seed)) % 40 : c];
         m = m * (90 + $unsigned($random(seed)) % 21) / 100;
         meas(c, t, m);
      end
      close_out();
   end
   initial begin
      #100000;
      num_errors++;
      close_out();
   end
endmodule : tb
`default_nettype wire
